// ---- dv/scanner_link_model.sv ----
// scanner far side: answers every frame with the data picked by its last command
// assumes frames arrive as one-cycle strobes on the system clock
module scanner_link_model (
    input wire logic clk_i, // system clock
    input wire logic [39:0] tx_xy_i, // {y, x}
    input wire logic tx_frame_i, // frame strobe
    input wire logic tx_is_cmd_i, // command frame
    output logic [39:0] rx_xy_o, // {y, x}
    output logic [19:0] rx_z_o, // z
    output logic rx_valid_o // answer strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [19:0] sel = 20'h00000;
    logic [1:0] cnt = 2'h0;
    initial begin
        rx_xy_o = 40'h0;
        rx_z_o = 20'h0;
        rx_valid_o = 1'b0;
    end
    always @(posedge clk_i) begin
        rx_valid_o <= 1'b0;
        // idle lines keep moving so a stale word is never mistaken for an answer
        rx_xy_o <= ~rx_xy_o;
        rx_z_o <= ~rx_z_o;
        if (tx_frame_i && tx_is_cmd_i) sel <= tx_xy_i[19:0];
        if (tx_frame_i) cnt <= 2'h2;
        else if (cnt != 2'h0) cnt <= cnt - 2'h1;
        if (cnt == 2'h1) begin
            rx_valid_o <= 1'b1;
            rx_xy_o <= {~sel, sel};
            rx_z_o <= sel ^ 20'h5a5a5;
        end
    end
endmodule : scanner_link_model

// ---- dv/tb.sv ----
// bench for the position interpolator: register port, interpolation clocks, scanner model
// assumes the register header on the include path
`include "scanner_interp_regs.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("ERROR %0t mismatch", $time); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import scanner_interp_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [5:0] reg_addr_i = 6'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic servo_clk_i = 1'b1;
    logic phase_clk_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic [39:0] planar_axes_tx_o, planar_axes_rx_i;
    logic [19:0] height_axis_tx_o, height_axis_rx_i;
    logic tx_frame_o, tx_is_cmd_o, rx_valid_i;
    logic rd_d = 1'b0, gap_chk = 1'b0, sel_ph = 1'b1;
    int fails = 0, compares = 0, gap = 0, ncnt = 0;
    logic [31:0] seed = 32'h5051fda8;
    logic [31:0] rq[$];
    logic [60:0] fq[$];
    pos24_t p1[3], cp[3];
    always #25 clk_sys_i = ~clk_sys_i;
    scanner_position_interpolator u_dut (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .servo_clk_i, .phase_clk_i, .planar_axes_tx_o, .height_axis_tx_o, .tx_frame_o,
        .tx_is_cmd_o, .planar_axes_rx_i, .height_axis_rx_i, .rx_valid_i);
    scanner_link_model u_scanner (.clk_i(clk_sys_i), .tx_xy_i(planar_axes_tx_o), .tx_frame_i(tx_frame_o),
        .tx_is_cmd_i(tx_is_cmd_o), .rx_xy_o(planar_axes_rx_i), .rx_z_o(height_axis_rx_i), .rx_valid_o(rx_valid_i));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [19:0] expw(pos24_t p, pos24_t c);
        logic signed [24:0] s;
        s = 25'(p) + 25'(c);
        if (s > `SI_POS_MAX) s = `SI_POS_MAX;
        if (s < `SI_POS_MIN) s = `SI_POS_MIN;
        return s[23:4];
    endfunction : expw
    // position i of the ramp: i = 0 old capture, i = 3 new capture
    function automatic logic [60:0] fexp(int i);
        pos24_t d;
        d = pos24_t'(i * 256);
        return {1'b0, expw(p1[2] + d, cp[2]), expw(p1[1] + d, cp[1]), expw(p1[0] + d, cp[0])};
    endfunction : fexp
    // k = 0: phase clock, sync, rising; k = 1: servo clock, async, falling
    function automatic logic [31:0] ctl(logic [2:0] code, logic k);
        return (32'(!k) << `SI_CLKSEL_BIT) | (32'(!k) << `SI_SYNC_BIT) | (32'(code) << `SI_CODE_LO)
            | (32'(!k) << `SI_EDGE_BIT);
    endfunction : ctl
    task automatic end_sim();
        if (fails == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task automatic wr(logic [5:0] a, logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : wr
    task automatic rd(logic [5:0] a, logic [31:0] e);
        rq.push_back(e);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : rd
    task automatic wait_frame();
        int i;
        i = 0;
        do begin
            @(posedge clk_sys_i);
            i++;
        end while (tx_frame_o !== 1'b1 && i < 1000);
        if (tx_frame_o !== 1'b1) begin
            fails++;
            end_sim();
        end
    endtask : wait_frame
    // one interpolation period of three frames, matching the host loop clock
    task automatic iclk(logic k, logic note);
        wait_frame();
        if (k) servo_clk_i <= 1'b0;
        else phase_clk_i <= 1'b1;
        // note after the edge's monitor pass, so the frame just seen is not taken for the ramp
        if (note) begin
            @(negedge clk_sys_i);
            for (int i = 0; i < 4; i++) fq.push_back(fexp(i));
        end
        wait_frame();
        wait_frame();
        if (k) servo_clk_i <= 1'b1;
        else phase_clk_i <= 1'b0;
    endtask : iclk
    // the unselected clock toggles so a wrong clock choice shows as stray captures
    always @(posedge clk_sys_i) begin
        ncnt <= (ncnt == 149) ? 0 : ncnt + 1;
        if (ncnt == 149 && sel_ph) servo_clk_i <= ~servo_clk_i;
        if (ncnt == 149 && !sel_ph) phase_clk_i <= ~phase_clk_i;
    end
    always @(posedge clk_sys_i) begin
        rd_d <= reg_rd_i;
        gap <= tx_frame_o ? 1 : gap + 1;
        if (rd_d && rq.size() > 0) `CHK(reg_rdata_o, rq.pop_front())
        if (tx_frame_o === 1'b1 && fq.size() > 0)
            `CHK({tx_is_cmd_o, height_axis_tx_o, planar_axes_tx_o}, fq.pop_front())
        if (tx_frame_o === 1'b1 && gap_chk) `CHK(gap, 200)
    end
    initial begin
        int k, a;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        rd(`SI_CTRL_OFS, `SI_CTRL_RST);
        wr(6'h3c, 32'hffff_ffff);
        rd(6'h3c, 32'h0);
        for (k = 0; k < 2; k++) begin
            sel_ph <= (k == 0);
            gap_chk <= 1'b0;
            wr(`SI_CTRL_OFS, ctl(`SI_CODE_POS, k[0]));
            rd(`SI_CTRL_OFS, ctl(`SI_CODE_POS, k[0]));
            p1[0] = pos24_t'(rnd() & 32'h3f_ffff);
            p1[1] = pos24_t'(rnd() & 32'h3f_ffff);
            p1[2] = -pos24_t'(rnd() & 32'h3f_ffff);
            cp[0] = pos24_t'($signed(rnd()) >>> 16);
            cp[1] = 24'sh7f_ffff;
            cp[2] = 24'sh80_0000;
            for (a = 0; a < 3; a++) begin
                wr(`SI_CMD_OFS + 6'(4 * a), {p1[a], 8'h00});
                wr(`SI_COMP_OFS + 6'(4 * a), {cp[a], 8'h00});
            end
            iclk(k[0], 1'b0);
            iclk(k[0], 1'b0);
            gap_chk <= k[0];
            for (a = 0; a < 3; a++) wr(`SI_CMD_OFS + 6'(4 * a), {p1[a] + 24'sh000300, 8'h00});
            iclk(k[0], 1'b1);
            iclk(k[0], 1'b0);
            iclk(k[0], 1'b0);
        end
        // high code 05 with its top bit inverted, low code 01
        wr(`SI_CTRL_OFS, ctl(`SI_CODE_CMD, 1'b1));
        for (a = 0; a < 3; a++) wr(`SI_CMD_OFS + 6'(4 * a), 32'h8501_0000);
        for (k = 0; k < 3; k++) begin
            if (k == 1) wr(`SI_CTRL_OFS, ctl(3'h2, 1'b1));
            if (k == 2) wr(`SI_CTRL_OFS, ctl(`SI_CODE_RESUME, 1'b1));
            wait_frame();
            @(negedge clk_sys_i);
            fq.push_back(k == 2 ? fexp(3) : {1'b1, {3{20'h85010}}});
            wait_frame();
            wait_frame();
        end
        for (a = 0; a < 3; a++)
            rd(`SI_READ_OFS + 6'(4 * a), {12'h0, 20'h85010 ^ (a == 1 ? 20'hfffff : a == 2 ? 20'h5a5a5 : 20'h0)});
        wr(`SI_READ_OFS, 32'hffff_ffff);
        rd(`SI_READ_OFS, 32'h0008_5010);
        `CHK(fq.size(), 0)
        end_sim();
    end
endmodule : tb

// ---- logic/scanner_position_interpolator.sv ----
// scanner position interpolator: 3 axis command/compensation, 10 us frames
// assumes synchronous clock pins and a single-cycle register port
`include "scanner_interp_regs.svh"
module scanner_position_interpolator (
    input wire logic clk_sys_i, // 20 MHz
    input wire logic rst_i, // async, high
    input wire logic [5:0] reg_addr_i, // byte address
    input wire logic [31:0] reg_wdata_i, // write data
    input wire logic reg_wr_i, // write strobe
    input wire logic reg_rd_i, // read strobe
    output logic [31:0] reg_rdata_o, // read data, next cycle
    input wire logic servo_clk_i, // servo clock level
    input wire logic phase_clk_i, // phase clock level
    output logic [39:0] planar_axes_tx_o, // {y, x}
    output logic [19:0] height_axis_tx_o, // z
    output logic tx_frame_o, // frame pulse
    output logic tx_is_cmd_o, // frame is a command
    input wire logic [39:0] planar_axes_rx_i, // {y, x}
    input wire logic [19:0] height_axis_rx_i, // z
    input wire logic rx_valid_i // returned data strobe
);
    import scanner_interp_pkg::*;
    localparam int NAX = `SI_NUM_AXES;
    localparam int FRAME_GAP = `SI_FRAME_CYC;
    localparam logic [7:0] FRAME_LAST = 8'(`SI_FRAME_CYC - 1);

    logic [31:0] ctrl_ff, nxt_ctrl, rdata_ff, nxt_rdata;
    logic [31:0] cmd_ff [NAX];
    logic [31:0] nxt_cmd [NAX];
    logic [31:0] comp_ff [NAX];
    logic [31:0] nxt_comp [NAX];
    logic [19:0] rd_ff [NAX];
    logic [19:0] nxt_rd [NAX];
    logic [19:0] rx_in [NAX];

    assign rx_in[0] = planar_axes_rx_i[19:0];
    assign rx_in[1] = planar_axes_rx_i[39:20];
    assign rx_in[2] = height_axis_rx_i;

    // register port; read data stands only in the cycle after the strobe
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_rdata = 32'h0;
        for (int k = 0; k < NAX; k++) begin
            nxt_cmd[k] = cmd_ff[k];
            nxt_comp[k] = comp_ff[k];
            nxt_rd[k] = rx_valid_i ? rx_in[k] : rd_ff[k];
        end
        if (reg_wr_i) begin
            if (reg_addr_i == `SI_CTRL_OFS) begin
                nxt_ctrl = reg_wdata_i;
            end
            for (int k = 0; k < NAX; k++) begin
                if (reg_addr_i == 6'(`SI_CMD_OFS + 4 * k)) begin
                    nxt_cmd[k] = reg_wdata_i;
                end
                if (reg_addr_i == 6'(`SI_COMP_OFS + 4 * k)) begin
                    nxt_comp[k] = reg_wdata_i;
                end
            end
        end
        if (reg_rd_i) begin
            if (reg_addr_i == `SI_CTRL_OFS) begin
                nxt_rdata = ctrl_ff;
            end
            for (int k = 0; k < NAX; k++) begin
                if (reg_addr_i == 6'(`SI_CMD_OFS + 4 * k)) begin
                    nxt_rdata = cmd_ff[k];
                end
                if (reg_addr_i == 6'(`SI_COMP_OFS + 4 * k)) begin
                    nxt_rdata = comp_ff[k];
                end
                if (reg_addr_i == 6'(`SI_READ_OFS + 4 * k)) begin
                    nxt_rdata = {12'h0, rd_ff[k]};
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_ff <= `SI_CTRL_RST;
            rdata_ff <= 32'h0;
            for (int k = 0; k < NAX; k++) begin
                cmd_ff[k] <= 32'h0;
                comp_ff[k] <= 32'h0;
                rd_ff[k] <= 20'h0;
            end
        end else begin
            ctrl_ff <= nxt_ctrl;
            rdata_ff <= nxt_rdata;
            cmd_ff <= nxt_cmd;
            comp_ff <= nxt_comp;
            rd_ff <= nxt_rd;
        end
    end
    assign reg_rdata_o = rdata_ff;

    logic sel_clk, sel_prev_ff, evt, tick, sync_mode;
    logic [2:0] code;
    logic [7:0] fcnt_ff, nxt_fcnt, nseen_ff, nxt_nseen, nper;
    tx_mode_t mode_ff, nxt_mode;

    assign code = ctrl_ff[`SI_CODE_HI:`SI_CODE_LO];
    assign sync_mode = ctrl_ff[`SI_SYNC_BIT];
    assign sel_clk = ctrl_ff[`SI_CLKSEL_BIT] ? phase_clk_i : servo_clk_i;
    assign evt = ctrl_ff[`SI_EDGE_BIT] ? (sel_clk & ~sel_prev_ff) : (~sel_clk & sel_prev_ff);
    assign tick = (fcnt_ff == FRAME_LAST);
    assign nper = (nseen_ff == 8'h0) ? 8'h1 : nseen_ff;

    // sync mode realigns the frame grid to each edge; async runs it free
    always_comb begin
        nxt_fcnt = fcnt_ff + 8'h1;
        if (tick || (evt && sync_mode)) begin
            nxt_fcnt = 8'h0;
        end
        nxt_nseen = nseen_ff;
        if (evt) begin
            nxt_nseen = 8'h0;
        end else if (tick && nseen_ff != 8'hff) begin
            nxt_nseen = nseen_ff + 8'h1;
        end
        case (code)
            `SI_CODE_POS, `SI_CODE_RESUME: nxt_mode = TX_POSITION;
            `SI_CODE_CMD: nxt_mode = TX_COMMAND;
            default: nxt_mode = mode_ff;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sel_prev_ff <= 1'b0;
            fcnt_ff <= 8'h0;
            nseen_ff <= 8'h0;
            mode_ff <= TX_POSITION;
        end else begin
            sel_prev_ff <= sel_clk;
            fcnt_ff <= nxt_fcnt;
            nseen_ff <= nxt_nseen;
            mode_ff <= nxt_mode;
        end
    end

    pos24_t cap_ff [NAX];
    pos24_t nxt_cap [NAX];
    acc_t acc_ff [NAX];
    acc_t nxt_acc [NAX];
    acc_t step_ff [NAX];
    acc_t nxt_step [NAX];
    logic [19:0] tx_ff [NAX];
    logic [19:0] nxt_tx [NAX];
    logic signed [24:0] sum [NAX];
    logic frame_ff, is_cmd_ff;

    // accumulator is 24.8: extra fraction keeps small steps from vanishing
    always_comb begin
        pos24_t newv;
        logic signed [32:0] diff, nx, tgt;
        pos24_t sat;
        newv = '0;
        diff = '0;
        nx = '0;
        tgt = '0;
        sat = '0;
        for (int k = 0; k < NAX; k++) begin
            nxt_cap[k] = cap_ff[k];
            nxt_acc[k] = acc_ff[k];
            nxt_step[k] = step_ff[k];
            nxt_tx[k] = tx_ff[k];
            tgt = 33'($signed({cap_ff[k], 8'h0}));
            if (evt) begin
                newv = (code == `SI_CODE_POS) ? pos24_t'(cmd_ff[k][31:8]) : cap_ff[k];
                // widen first: a full-range jump does not fit in 24 bits
                diff = (33'(newv) - 33'(cap_ff[k])) <<< `SI_EXT_FRAC;
                nxt_step[k] = acc_t'(diff / $signed({25'h0, nper}));
                nxt_acc[k] = acc_t'({cap_ff[k], 8'h0});
                nxt_cap[k] = newv;
            end else if (tick) begin
                nx = 33'(acc_ff[k]) + 33'(step_ff[k]);
                // stop at the target; async periods may not divide evenly
                if ((step_ff[k] > 0 && nx > tgt) || (step_ff[k] < 0 && nx < tgt)) begin
                    nx = tgt;
                end
                nxt_acc[k] = acc_t'(nx);
            end
            sum[k] = 25'($signed(acc_ff[k][31:8])) + 25'($signed(comp_ff[k][31:8]));
            if (sum[k] > `SI_POS_MAX) begin
                sat = 24'h7f_ffff;
            end else if (sum[k] < `SI_POS_MIN) begin
                sat = 24'h80_0000;
            end else begin
                sat = sum[k][23:0];
            end
            if (tick) begin
                nxt_tx[k] = (mode_ff == TX_COMMAND) ? cmd_ff[k][31:12] : sat[23:4];
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            frame_ff <= 1'b0;
            is_cmd_ff <= 1'b0;
            for (int k = 0; k < NAX; k++) begin
                cap_ff[k] <= '0;
                acc_ff[k] <= '0;
                step_ff[k] <= '0;
                tx_ff[k] <= 20'h0;
            end
        end else begin
            frame_ff <= tick;
            if (tick) begin
                is_cmd_ff <= (mode_ff == TX_COMMAND);
            end
            cap_ff <= nxt_cap;
            acc_ff <= nxt_acc;
            step_ff <= nxt_step;
            tx_ff <= nxt_tx;
        end
    end

    assign planar_axes_tx_o = {tx_ff[1], tx_ff[0]};
    assign height_axis_tx_o = tx_ff[2];
    assign tx_frame_o = frame_ff;
    assign tx_is_cmd_o = is_cmd_ff;

    AST_FRAME_PERIOD: assert property (@(posedge clk_sys_i) disable iff (rst_i || sync_mode)
        tx_frame_o |-> ##FRAME_GAP tx_frame_o) else $error("frame period wrong");
    AST_FRAME_GAP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        tx_frame_o |=> !tx_frame_o [*8]) else $error("frames too close");
    AST_RISE_SERVO: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ($rose(servo_clk_i) && $stable(ctrl_ff) && !ctrl_ff[`SI_CLKSEL_BIT] && ctrl_ff[`SI_EDGE_BIT]) |-> evt)
        else $error("servo rise missed");
    AST_FALL_PHASE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ($fell(phase_clk_i) && $stable(ctrl_ff) && ctrl_ff[`SI_CLKSEL_BIT] && !ctrl_ff[`SI_EDGE_BIT]) |-> evt)
        else $error("phase fall missed");
    AST_LATCH: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (evt && code == `SI_CODE_POS) |=> cap_ff[0] == $past(cmd_ff[0][31:8])) else $error("no latch");
    AST_SEND_NEXT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        evt |=> acc_ff[0][31:8] == $past(cap_ff[0])) else $error("start not previous capture");
    AST_SATURATE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (tick && mode_ff == TX_POSITION && sum[1] > `SI_POS_MAX) |=> planar_axes_tx_o[39:20] == 20'h7ffff)
        else $error("no saturation");
    AST_CMD_TX: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (tick && mode_ff == TX_COMMAND) |=> tx_is_cmd_o && height_axis_tx_o == $past(cmd_ff[2][31:12]))
        else $error("command frame wrong");
    AST_MODE_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (code != `SI_CODE_POS && code != `SI_CODE_RESUME && code != `SI_CODE_CMD) |=> $stable(mode_ff))
        else $error("mode changed");
    AST_READ_BACK: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (rx_valid_i ##1 (reg_rd_i && reg_addr_i == `SI_READ_OFS && !rx_valid_i))
        |=> reg_rdata_o == {12'h0, $past(planar_axes_rx_i[19:0], 2)}) else $error("read data lost");
endmodule : scanner_position_interpolator

// ---- shared/scanner_interp_pkg.sv ----
// types shared by the interpolator and its bench
// assumes nothing of its surroundings
package scanner_interp_pkg;
    typedef enum {TX_POSITION, TX_COMMAND} tx_mode_t;
    typedef logic signed [23:0] pos24_t;
    typedef logic signed [31:0] acc_t;
endpackage : scanner_interp_pkg

// ---- shared/scanner_interp_regs.svh ----
// register offsets, field positions, reset values and timing counts
// included by the interpolator and its bench
`ifndef SCANNER_INTERP_REGS_SVH
`define SCANNER_INTERP_REGS_SVH
`define SI_NUM_AXES 3
`define SI_ADDR_W 6
`define SI_CTRL_OFS 6'h00
`define SI_CMD_OFS 6'h04
`define SI_COMP_OFS 6'h10
`define SI_READ_OFS 6'h1c
`define SI_CLKSEL_BIT 17
`define SI_SYNC_BIT 16
`define SI_CODE_HI 15
`define SI_CODE_LO 13
`define SI_EDGE_BIT 12
`define SI_CODE_POS 3'h1
`define SI_CODE_RESUME 3'h4
`define SI_CODE_CMD 3'h7
`define SI_CTRL_RST 32'h0000_0000
`define SI_FRAME_NS 10000
`define SI_CLK_NS 50
`define SI_FRAME_CYC (`SI_FRAME_NS / `SI_CLK_NS)
`define SI_EXT_FRAC 8
`define SI_POS_MAX 25'sh07f_ffff
`define SI_POS_MIN 25'sh180_0000
`endif
